// >>> rtl/strt_top.sv
// start trigger selection and signal routing matrix
`timescale 1ns/100ps
`default_nettype none
`include "strt_regs.svh"
// Operation
// - immediate source starts on initiate
// - software source waits for soft trigger
// - external source waits for rising edge
// - immediate source applies settings at once
// - triggered source holds settings until trigger
// - default immediate; four trigger sources selectable
// - continuous mode runs until stop
// - disable or abort stops output
// - sine and square emitted once started
// - backplane line routes to any destination
// - line destinations select from listed sources
// - divisor at least three, resets three
// - null source clears destination routes
// - board clock derived source at 12.5 megahertz, a quarter of CLOCK, at front and ref out; divided on lines
// - destinations: ref out, front, lines, line 7
// - one enable gates sine and square
module strt_top
    import strt_pkg::*;
#(
    parameter int NLINES = `STRT_NUM_LINES,
    parameter int PW = 32
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // commands, one-cycle pulses; OUT_ENABLE is a held level
    input wire logic INITIATE,
    input wire logic ABORT,
    input wire logic SOFT_TRIG,
    input wire logic OUT_ENABLE,
    // start configuration
    input wire logic [2:0] START_SEL,
    input wire logic [2:0] START_LINE,
    // synthesis settings
    input wire logic [PW-1:0] FREQ_IN,
    input wire logic [PW-1:0] PHASE_IN,
    input wire logic [PW-1:0] AMPL_IN,
    input wire logic PARAM_WR,
    output logic [PW-1:0] FREQ_OUT,
    output logic [PW-1:0] PHASE_OUT,
    output logic [PW-1:0] AMPL_OUT,
    output logic PARAM_LOAD,
    // route setup: source code, destination, write pulse
    input wire logic [3:0] ROUTE_SRC,
    input wire logic [2:0] ROUTE_SRC_LINE,
    input wire logic [1:0] ROUTE_DST,
    input wire logic [2:0] ROUTE_DST_LINE,
    input wire logic ROUTE_WR,
    input wire logic [7:0] DIV_IN,
    input wire logic DIV_WR,
    // internal signals to route
    input wire logic SQUARE_IN,
    input wire logic REF_IN,
    input wire logic CLK10_IN,
    // pins
    input wire logic STAR_IN,
    input wire logic FRONT_IN,
    output logic FRONT_OUT,
    output logic FRONT_OE_B,
    input wire logic [NLINES-1:0] LINE_IN,
    output logic [NLINES-1:0] LINE_OUT,
    output logic [NLINES-1:0] LINE_OE_B,
    output logic REF_OUT,
    // generation status and output gates
    output logic RUNNING,
    output logic ARMED,
    output logic SINE_EN,
    output logic SQUARE_EN,
    output logic START_PULSE
);
    localparam int BC_RATIO = `STRT_CLK_HZ / `STRT_BOARD_CLK_HZ;
    localparam int NDST = NLINES + 2;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [NLINES+1:0] ext_lvl;
    logic [NLINES+1:0] ext_rise;
    logic [NLINES+1:0] ext_raw;
    assign ext_raw = {STAR_IN, FRONT_IN, LINE_IN};
    genvar gi;
    generate
        for (gi = 0; gi < NLINES + 2; gi++)
        begin : g_sync
            strt_sync u_sync
            (
                .clk(CLOCK),
                .rst_b(RST_B),
                .din(ext_raw[gi]),
                .level(ext_lvl[gi]),
                .rise(ext_rise[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // start control
    // ------------------------------------------------------------
    strt_state_e st_reg;
    strt_state_e st_next;
    logic [2:0] sel_reg;
    logic [2:0] sel_next;
    logic trig;
    logic start_p;
    logic pend_reg;
    logic pend_next;
    logic [PW-1:0] pf_reg, pp_reg, pa_reg, pf_next, pp_next, pa_next;
    logic [PW-1:0] of_reg, op_reg, oa_reg, of_next, op_next, oa_next;
    logic load_reg;
    logic load_next;
    logic oe_reg;
    logic oe_next;

    always_comb
    begin
        unique case (strt_start_e'(sel_reg))
            STRT_SS_SOFT: trig = SOFT_TRIG;
            STRT_SS_FRONT: trig = ext_rise[NLINES];
            STRT_SS_LINE: trig = ext_rise[START_LINE];
            STRT_SS_STAR: trig = ext_rise[NLINES+1];
            default: trig = 1'b0;
        endcase
    end

    always_comb
    begin
        st_next = st_reg;
        sel_next = sel_reg;
        start_p = 1'b0;
        pend_next = pend_reg;
        pf_next = pf_reg;
        pp_next = pp_reg;
        pa_next = pa_reg;
        of_next = of_reg;
        op_next = op_reg;
        oa_next = oa_reg;
        load_next = 1'b0;
        oe_next = OUT_ENABLE;
        if (PARAM_WR)
        begin
            pf_next = FREQ_IN;
            pp_next = PHASE_IN;
            pa_next = AMPL_IN;
            pend_next = 1'b1;
        end
        unique case (st_reg)
            STRT_ST_IDLE:
            begin
                sel_next = START_SEL;
                if (INITIATE)
                begin
                    if (START_SEL == STRT_SS_ONCE)
                    begin
                        st_next = STRT_ST_RUN;
                        start_p = 1'b1;
                    end
                    else
                    begin
                        st_next = STRT_ST_ARMED;
                    end
                end
            end
            STRT_ST_ARMED:
            begin
                if (trig)
                begin
                    st_next = STRT_ST_RUN;
                    start_p = 1'b1;
                end
            end
            STRT_ST_RUN:
            begin
                // continuous: only abort leaves
                start_p = trig;
            end
            default: st_next = STRT_ST_IDLE;
        endcase
        // immediate mode pushes writes now, else on trigger
        if ((sel_reg == STRT_SS_ONCE && st_reg == STRT_ST_RUN && PARAM_WR) || (start_p && (pend_reg || PARAM_WR)))
        begin
            of_next = pf_next;
            op_next = pp_next;
            oa_next = pa_next;
            load_next = 1'b1;
            pend_next = 1'b0;
        end
        if (ABORT)
        begin
            st_next = STRT_ST_IDLE;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_reg <= STRT_ST_IDLE;
            sel_reg <= 3'h0;
            pend_reg <= 1'b0;
            pf_reg <= '0;
            pp_reg <= '0;
            pa_reg <= '0;
            of_reg <= '0;
            op_reg <= '0;
            oa_reg <= '0;
            load_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            sel_reg <= sel_next;
            pend_reg <= pend_next;
            pf_reg <= pf_next;
            pp_reg <= pp_next;
            pa_reg <= pa_next;
            of_reg <= of_next;
            op_reg <= op_next;
            oa_reg <= oa_next;
            load_reg <= load_next;
            oe_reg <= oe_next;
        end
    end

    logic sp_reg;
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            sp_reg <= 1'b0;
        else
            sp_reg <= start_p;
    end

    assign RUNNING = (st_reg == STRT_ST_RUN);
    assign ARMED = (st_reg == STRT_ST_ARMED);
    assign SINE_EN = RUNNING & oe_reg;
    assign SQUARE_EN = RUNNING & oe_reg;
    assign START_PULSE = sp_reg;
    assign FREQ_OUT = of_reg;
    assign PHASE_OUT = op_reg;
    assign AMPL_OUT = oa_reg;
    assign PARAM_LOAD = load_reg;

    // ------------------------------------------------------------
    // board clock and divided board clock
    // ------------------------------------------------------------
    logic [7:0] div_reg, div_next, dcnt_reg, dcnt_next, bcnt_reg, bcnt_next;
    logic bclk_reg, bclk_next, dclk_reg, dclk_next;
    always_comb
    begin
        div_next = div_reg;
        if (DIV_WR)
            div_next = (DIV_IN < `STRT_DIV_MIN) ? `STRT_DIV_MIN : DIV_IN;
        bcnt_next = bcnt_reg + 8'h01;
        bclk_next = bclk_reg;
        dcnt_next = dcnt_reg;
        dclk_next = dclk_reg;
        // board clock toggles at ratio-limited rate
        if (bcnt_reg >= 8'(BC_RATIO / 2))
        begin
            bcnt_next = 8'h00;
            bclk_next = ~bclk_reg;
            if (!bclk_reg)
            begin
                dcnt_next = dcnt_reg + 8'h01;
                if (dcnt_reg + 8'h01 >= div_reg)
                begin
                    dcnt_next = 8'h00;
                end
                dclk_next = (dcnt_next < (div_reg >> 1));
            end
        end
    end
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            div_reg <= `STRT_DIV_RESET;
            dcnt_reg <= 8'h00;
            bcnt_reg <= 8'h00;
            bclk_reg <= 1'b0;
            dclk_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            dcnt_reg <= dcnt_next;
            bcnt_reg <= bcnt_next;
            bclk_reg <= bclk_next;
            dclk_reg <= dclk_next;
        end
    end

    // ------------------------------------------------------------
    // routing matrix: dest 0..NLINES-1 lines, NLINES front, NLINES+1 ref out
    // ------------------------------------------------------------
    logic [3:0] rsrc_reg [NDST];
    logic [2:0] rlin_reg [NDST];
    logic [NDST-1:0] val;
    int dsel;
    always_comb
    begin
        unique case (ROUTE_DST)
            2'h0: dsel = NLINES + 1;
            2'h1: dsel = NLINES;
            2'h2: dsel = int'(ROUTE_DST_LINE);
            default: dsel = `STRT_CLKLINE_IDX;
        endcase
    end
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            for (int i = 0; i < NDST; i++)
            begin
                rsrc_reg[i] <= 4'h0;
                rlin_reg[i] <= 3'h0;
            end
        end
        else if (ROUTE_WR)
        begin
            rsrc_reg[dsel] <= ROUTE_SRC;
            rlin_reg[dsel] <= ROUTE_SRC_LINE;
        end
    end
    always_comb
    begin
        for (int d = 0; d < NDST; d++)
        begin
            unique case (strt_route_e'(rsrc_reg[d]))
                STRT_RS_SQUARE: val[d] = SQUARE_IN;
                STRT_RS_START: val[d] = sp_reg;
                STRT_RS_SOFT: val[d] = SOFT_TRIG;
                // lines get only the divided clock, never full board clock
                STRT_RS_BOARD: val[d] = (d < NLINES) ? dclk_reg : bclk_reg;
                STRT_RS_REFIN: val[d] = REF_IN;
                STRT_RS_CLK10: val[d] = CLK10_IN;
                STRT_RS_STAR: val[d] = ext_lvl[NLINES+1];
                STRT_RS_FRONT: val[d] = ext_lvl[NLINES];
                STRT_RS_LINE: val[d] = ext_lvl[rlin_reg[d]];
                default: val[d] = 1'b0;
            endcase
        end
    end
    always_comb
    begin
        for (int d = 0; d < NLINES; d++)
        begin
            LINE_OE_B[d] = (rsrc_reg[d] == STRT_RS_NULL);
        end
    end
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            LINE_OUT <= '0;
            FRONT_OUT <= 1'b0;
            REF_OUT <= 1'b0;
        end
        else
        begin
            LINE_OUT <= val[NLINES-1:0];
            FRONT_OUT <= val[NLINES];
            REF_OUT <= val[NLINES+1];
        end
    end
    assign FRONT_OE_B = (rsrc_reg[NLINES] == STRT_RS_NULL);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_once_start: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (st_reg == STRT_ST_IDLE && INITIATE && !ABORT && START_SEL == 3'h0) |=> RUNNING)
        else $error("immediate start missed");
    a_soft_wait: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (ARMED && sel_reg == 3'h1 && !SOFT_TRIG && !ABORT) |=> ARMED)
        else $error("soft start left armed early");
    a_ext_edge: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (ARMED && sel_reg == 3'h2 && ext_rise[NLINES] && !ABORT) |=> RUNNING)
        else $error("front edge did not start");
    a_once_update: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (RUNNING && sel_reg == 3'h0 && PARAM_WR) |=> (FREQ_OUT == $past(FREQ_IN) && PARAM_LOAD))
        else $error("immediate update late");
    a_hold_pend: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (RUNNING && sel_reg != 3'h0 && !trig) |=> $stable(FREQ_OUT))
        else $error("pending setting leaked");
    a_run_stays: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (RUNNING && !ABORT) |=> RUNNING)
        else $error("generation stopped");
    a_abort_stop: assert property (@(posedge CLOCK) disable iff (!RST_B)
        ABORT |=> (!SINE_EN && !SQUARE_EN))
        else $error("abort did not stop output");
    a_div_floor: assert property (@(posedge CLOCK) disable iff (!RST_B)
        div_reg >= `STRT_DIV_MIN)
        else $error("divisor below three");
    a_null_clear: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (ROUTE_WR && ROUTE_SRC == 4'h0 && ROUTE_DST == 2'h1) |=> FRONT_OE_B)
        else $error("null route did not clear");
    a_gate_same: assert property (@(posedge CLOCK) disable iff (!RST_B)
        SINE_EN == SQUARE_EN)
        else $error("outputs gated apart");
    c_soft_start: cover property (@(posedge CLOCK) disable iff (!RST_B) ARMED && sel_reg == 3'h1 ##1 RUNNING);
    c_ext_start: cover property (@(posedge CLOCK) disable iff (!RST_B) ARMED && sel_reg == 3'h3 ##1 RUNNING);
    c_pend_apply: cover property (@(posedge CLOCK) disable iff (!RST_B) RUNNING && pend_reg && trig);
endmodule : strt_top
`default_nettype wire

// >>> rtl/strt_regs.svh
// constants of the start trigger and signal routing block
`ifndef STRT_REGS_SVH
`define STRT_REGS_SVH
`define STRT_NUM_LINES 8
`define STRT_CLKLINE_IDX 7
`define STRT_CLK_HZ 50000000
`define STRT_BOARD_CLK_HZ 20000000
`define STRT_LINE_MAX_HZ 20000000
`define STRT_DIV_MIN 8'h03
`define STRT_DIV_RESET 8'h03
`define STRT_SRC_W 4
`endif

// >>> rtl/strt_pkg.sv
// types of the start trigger and signal routing block
package strt_pkg;
    typedef enum logic [2:0] {
        STRT_SS_ONCE = 3'h0,
        STRT_SS_SOFT = 3'h1,
        STRT_SS_FRONT = 3'h2,
        STRT_SS_LINE = 3'h3,
        STRT_SS_STAR = 3'h4
    } strt_start_e;
    // route sources; a backplane line source is the line code plus a separate line index
    typedef enum logic [3:0] {
        STRT_RS_NULL = 4'h0,
        STRT_RS_SQUARE = 4'h1,
        STRT_RS_START = 4'h2,
        STRT_RS_SOFT = 4'h3,
        STRT_RS_BOARD = 4'h4,
        STRT_RS_REFIN = 4'h5,
        STRT_RS_CLK10 = 4'h6,
        STRT_RS_STAR = 4'h7,
        STRT_RS_FRONT = 4'h8,
        STRT_RS_LINE = 4'h9
    } strt_route_e;
    typedef enum logic [1:0] {
        STRT_ST_IDLE = 2'h0,
        STRT_ST_ARMED = 2'h1,
        STRT_ST_RUN = 2'h3
    } strt_state_e;
endpackage : strt_pkg

// >>> rtl/strt_sync.sv
// three-stage input synchroniser with rising edge detect
`timescale 1ns/100ps
`default_nettype none
module strt_sync
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // async level in
    input wire logic din,
    // synchronised level and rising edge
    output logic level,
    output logic rise
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;
    logic lvl_reg;
    logic lvl_next;

    always_comb
    begin
        sh_next = {sh_reg[1:0], din};
        lvl_next = (sh_reg[2] == sh_reg[1]) ? sh_reg[1] : lvl_reg;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sh_reg <= 3'h0;
            lvl_reg <= 1'b0;
        end
        else
        begin
            sh_reg <= sh_next;
            lvl_reg <= lvl_next;
        end
    end

    assign level = lvl_reg;
    // filtered level low, then two agreeing high samples
    assign rise = lvl_next & ~lvl_reg;
endmodule : strt_sync
`default_nettype wire

// >>> tb/strt_far_end.sv
// far-side model of backplane pins and clock sources
`timescale 1ns/100ps
`default_nettype none
module strt_far_end
(
    // clock
    input wire logic clk,
    // pins and sources toward the block
    output logic front,
    output logic star,
    output logic [7:0] line,
    output logic ref_in,
    output logic clk10
);
    logic [2:0] cnt;
    initial
    begin
        front = 1'b0;
        star = 1'b0;
        line = 8'h00;
        ref_in = 1'b0;
        clk10 = 1'b0;
        cnt = 3'h0;
    end
    // ----
    // sources
    // ----
    always @(posedge clk)
    begin
        ref_in <= ~ref_in;
        cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
        if (cnt == 3'h4)
            clk10 <= ~clk10;
    end
    // ----
    // pin level: 0 front, 1 star, 2+n line n
    // ----
    task automatic drive(input int k, input logic v);
        @(posedge clk);
        if (k == 0)
            front <= v;
        else if (k == 1)
            star <= v;
        else
            line[k-2] <= v;
    endtask : drive
endmodule : strt_far_end
`default_nettype wire

// >>> tb/strt_top_tb_top.sv
// self-checking bench of the start trigger and routing block
`timescale 1ns/100ps
`default_nettype none
module strt_top_tb_top;
    logic clock, rst_b, out_enable;
    logic [5:0] pls;
    logic [2:0] start_sel, start_line, src_line, dst_line;
    logic [31:0] freq_in, phase_in, ampl_in, freq_out, phase_out, ampl_out;
    logic [3:0] route_src;
    logic [1:0] route_dst;
    logic [7:0] div_in, line_in, line_out, line_oe_b, far_line;
    logic front_in, front_out, front_oe_b, far_front, far_star, far_ref, far_clk10;
    logic param_load, ref_out, running, armed, sine_en, square_en, start_pulse;
    int miscompares, comparisons, n;
    // ----
    // wire levels and instances
    // ----
    assign line_in = (line_oe_b & far_line) | (~line_oe_b & line_out);
    assign front_in = front_oe_b ? far_front : front_out;
    strt_top dut (
        .CLOCK(clock), .RST_B(rst_b), .INITIATE(pls[0]), .ABORT(pls[1]), .SOFT_TRIG(pls[2]),
        .OUT_ENABLE(out_enable), .START_SEL(start_sel), .START_LINE(start_line),
        .FREQ_IN(freq_in), .PHASE_IN(phase_in), .AMPL_IN(ampl_in), .PARAM_WR(pls[3]),
        .FREQ_OUT(freq_out), .PHASE_OUT(phase_out), .AMPL_OUT(ampl_out), .PARAM_LOAD(param_load),
        .ROUTE_SRC(route_src), .ROUTE_SRC_LINE(src_line), .ROUTE_DST(route_dst),
        .ROUTE_DST_LINE(dst_line), .ROUTE_WR(pls[4]), .DIV_IN(div_in), .DIV_WR(pls[5]),
        .SQUARE_IN(~far_ref), .REF_IN(far_ref), .CLK10_IN(far_clk10), .STAR_IN(far_star),
        .FRONT_IN(front_in), .FRONT_OUT(front_out), .FRONT_OE_B(front_oe_b), .LINE_IN(line_in),
        .LINE_OUT(line_out), .LINE_OE_B(line_oe_b), .REF_OUT(ref_out), .RUNNING(running),
        .ARMED(armed), .SINE_EN(sine_en), .SQUARE_EN(square_en), .START_PULSE(start_pulse)
    );
    strt_far_end far (.clk(clock), .front(far_front), .star(far_star), .line(far_line),
        .ref_in(far_ref), .clk10(far_clk10));
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ----
    // shared tasks
    // ----
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick
    task automatic pulse(input logic [5:0] m);
        @(posedge clock);
        pls <= m;
        @(posedge clock);
        pls <= 6'h00;
        #1;
    endtask : pulse
    task automatic params(input logic [31:0] v);
        @(posedge clock);
        freq_in <= v;
        phase_in <= ~v;
        ampl_in <= v ^ 32'h00ff00ff;
        pulse(6'h08);
    endtask : params
    task automatic expect_params(input logic [31:0] v);
        check("freq", freq_out, v);
        check("phase", phase_out, ~v);
        check("ampl", ampl_out, v ^ 32'h00ff00ff);
    endtask : expect_params
    task automatic wait_load();
        for (n = 0; n < 8 && param_load !== 1'b1; n++)
            tick();
        check("load", param_load, 1);
    endtask : wait_load
    task automatic route(input logic [3:0] s, input logic [2:0] sl, input logic [1:0] d,
        input logic [2:0] dl);
        @(posedge clock);
        route_src <= s;
        src_line <= sl;
        route_dst <= d;
        dst_line <= dl;
        pulse(6'h10);
        repeat (2) tick();
    endtask : route
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    // ----
    // scenarios
    // ----
    task automatic t_once();
        check("idle oe", front_oe_b, 1);
        @(posedge clock);
        out_enable <= 1'b1;
        pulse(6'h01);
        check("run", running, 1);
        check("sine", sine_en, 1);
        check("square", square_en, 1);
        params(32'h00001234);
        wait_load();
        expect_params(32'h00001234);
        @(posedge clock);
        out_enable <= 1'b0;
        repeat (3) tick();
        check("sine off", sine_en, 0);
        check("square off", square_en, 0);
        check("still run", running, 1);
        @(posedge clock);
        out_enable <= 1'b1;
        pulse(6'h02);
        tick();
        check("abort", running, 0);
        check("sine abort", sine_en, 0);
    endtask : t_once
    task automatic t_soft();
        @(posedge clock);
        start_sel <= 3'h1;
        pulse(6'h01);
        params(32'h00000a0a);
        repeat (2) tick();
        check("armed", armed, 1);
        check("held", running, 0);
        expect_params(32'h00001234);
        pulse(6'h04);
        wait_load();
        check("pulse", start_pulse, 1);
        check("run", running, 1);
        expect_params(32'h00000a0a);
        params(32'h00005555);
        repeat (3) tick();
        expect_params(32'h00000a0a);
        pulse(6'h04);
        wait_load();
        expect_params(32'h00005555);
        check("run on", running, 1);
        pulse(6'h02);
    endtask : t_soft
    task automatic t_ext();
        logic [2:0] sel [3] = '{3'h2, 3'h3, 3'h4};
        int pin [3] = '{0, 7, 1};
        int cnt;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock);
            start_sel <= sel[i];
            start_line <= 3'h5;
            pulse(6'h01);
            repeat (4) tick();
            check("wait edge", running, 0);
            far.drive(pin[i], 1'b1);
            cnt = 0;
            for (int j = 0; j < 10; j++)
            begin
                tick();
                cnt += (start_pulse === 1'b1);
            end
            check("edge run", running, 1);
            check("one pulse", cnt, 1);
            far.drive(pin[i], 1'b0);
            pulse(6'h02);
        end
    endtask : t_ext
    task automatic t_route();
        route(4'h9, 3'h2, 2'h1, 3'h0);
        check("front oe", front_oe_b, 0);
        far.drive(4, 1'b1);
        repeat (6) tick();
        check("front hi", front_out, 1);
        route(4'h9, 3'h2, 2'h2, 3'h5);
        check("line hi", line_out[5], 1);
        route(4'h9, 3'h2, 2'h0, 3'h0);
        check("ref hi", ref_out, 1);
        far.drive(4, 1'b0);
        repeat (6) tick();
        check("front lo", front_out, 0);
        check("ref lo", ref_out, 0);
        route(4'h0, 3'h0, 2'h1, 3'h0);
        check("front clear", front_oe_b, 1);
        route(4'h6, 3'h0, 2'h3, 3'h0);
        check("clk line", line_oe_b[7], 0);
        for (int s = 1; s < 10; s++)
        begin
            route(s[3:0], 3'h2, 2'h2, 3'h3);
            check("line src", line_oe_b[3], 0);
        end
        route(4'h0, 3'h0, 2'h2, 3'h3);
        check("line clear", line_oe_b[3], 1);
    endtask : t_route
    task automatic t_div();
        logic p;
        int ups, gap, fast;
        route(4'h4, 3'h0, 2'h2, 3'h0);
        for (int k = 0; k < 2; k++)
        begin
            p = line_out[0];
            {ups, fast} = '0;
            gap = 8;
            for (int i = 0; i < 120; i++)
            begin
                tick();
                gap++;
                if (line_out[0] !== p)
                begin
                    fast += (gap < 3);
                    ups += (line_out[0] === 1'b1);
                    gap = 0;
                end
                p = line_out[0];
            end
            check("board toggles", ups > 0, 1);
            check("too fast", fast, 0);
            check("div three", ups, 10);
            // second pass: a divisor below the floor is clamped
            @(posedge clock);
            div_in <= 8'h01;
            pulse(6'h20);
        end
    endtask : t_div
    // ----
    // main sequence and watchdog
    // ----
    initial
    begin
        {rst_b, pls, out_enable, start_sel, start_line, src_line, dst_line} = '0;
        {freq_in, phase_in, ampl_in, route_src, route_dst, div_in} = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        tick();
        check("reset run", running, 0);
        check("reset lines", line_oe_b, 8'hff);
        t_once();
        t_soft();
        t_ext();
        t_route();
        t_div();
        report_and_stop();
    end
    initial
    begin
        #100us;
        miscompares++;
        report_and_stop();
    end
endmodule : strt_top_tb_top
`default_nettype wire
